// ===== src/cwfm_regs_top.sv
// register bank holding the reference can wake-up frame for selective wake
// assumes an avalon-mm master on clk and a frame comparator reading the outputs
//
// Summary of operation
// - a mask bit of one compares that identifier bit, zero ignores it
// - extension flag bit 0: zero standard 11-bit, one extended 29-bit id
// - request flag bit 1: zero data frame, one remote request
// - id 20..13, 12..5 fill full bytes; id 4..0 sit at bits 6:2
// - mask bits 28..21, 20..13, 12..5 each fill one full byte
// - mask 4..0 at bits 6:2 of low mask; bits 7, 1:0 reserved
// - reserved bits always read back as zero
// - length code is four bits; codes 0 to 7 give that many bytes
// - length codes above eight mean an eight-byte data field
// - payload bytes seven and six are full read-write bytes
// - power-on or soft reset clears every register to zero
// - restart keeps the stored bytes but clears config valid; reserved bits still read zero
// - config valid set by software, cleared on wake, reset, config change
// - identifier bits 28..21 fill the first stored byte of this bank, index 6'h23
`timescale 1ns/100ps
`default_nettype none

module cwfm_regs_top
  import cwfm_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic soft_reset,
  input wire logic restart_pulse,
  input wire logic wake_event,
  input wire logic [cwfm_pkg::CWFM_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic [28:0] ref_ident,
  output logic [28:0] cmp_mask,
  output logic [10:0] ref_std_ident,
  output logic ref_ide,
  output logic ref_rtr,
  output logic rtr_misconfig,
  output logic [3:0] ref_length_code,
  output logic [3:0] ref_byte_count,
  output logic [7:0] ref_payload_byte_seven,
  output logic [7:0] ref_payload_byte_six,
  output logic config_valid_flag
);
  import cwfm_pkg::*;

  // ----------------------------------------------------------------
  // address decoding helpers
  // ----------------------------------------------------------------

  // true when an index falls on one of the eleven stored bytes
  function automatic logic slot_hit(input logic [5:0] idx);
    slot_hit = (idx >= CWFM_IDX_WAKE_ID_TOP) && (idx <= CWFM_IDX_BYTE_SIX);
  endfunction

  // storage slot of an index; only meaningful where slot_hit is true
  function automatic logic [3:0] slot_of(input logic [5:0] idx);
    logic [5:0] diff;
    diff = idx - CWFM_IDX_WAKE_ID_TOP;
    slot_of = diff[3:0];
  endfunction

  // writable bits per slot; everything else is reserved and stays zero
  function automatic cwfm_byte_t wmask_of(input logic [3:0] slot);
    case (slot)
      CWFM_SLOT_ID_LOW_FLAGS: wmask_of = CWFM_WMASK_ID_LOW_FLAGS;
      CWFM_SLOT_MASK_LOW: wmask_of = CWFM_WMASK_MASK_LOW;
      CWFM_SLOT_LENGTH_CODE: wmask_of = CWFM_WMASK_LENGTH_CODE;
      default: wmask_of = CWFM_WMASK_FULL;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------

  cwfm_acc_if acc ();

  cwfm_avmm_slave u_slave (
    .clk(clk),
    .srst(srst),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .acc(acc)
  );

  // ----------------------------------------------------------------
  // access qualification
  // ----------------------------------------------------------------

  logic cfg_write;
  logic ctrl_write;
  logic [3:0] wr_slot;
  cwfm_byte_t wr_byte;

  // a completed write to a stored byte, or to the control word
  assign cfg_write = acc.wr_stb & slot_hit(acc.idx);
  assign ctrl_write = acc.wr_stb & (acc.idx == CWFM_IDX_CONFIG_VALID);
  assign wr_slot = slot_of(acc.idx);
  // reserved positions are stripped before anything is stored
  assign wr_byte = acc.wdata & wmask_of(wr_slot);

  // ----------------------------------------------------------------
  // reference frame storage
  // ----------------------------------------------------------------

  cwfm_byte_t slot_reg [CWFM_NUM_SLOTS];

  // one flop byte per slot; restart_pulse has no branch on purpose,
  // so a restart leaves every stored byte untouched
  genvar g;
  generate
    for (g = 0; g < CWFM_NUM_SLOTS; g++)
    begin : g_slot
      always_ff @(posedge clk)
      begin
        if (srst || soft_reset)
          slot_reg[g] <= CWFM_BYTE_RESET;
        else if (cfg_write && (wr_slot == 4'(g)))
          slot_reg[g] <= wr_byte;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // configuration valid flag
  // ----------------------------------------------------------------

  logic cfg_valid_reg;
  logic cfg_valid_next;

  // clearing events win over a software set in the same cycle, so a
  // stale configuration can never be armed across a wake or an edit
  always_comb
  begin
    cfg_valid_next = cfg_valid_reg;
    if (ctrl_write)
      cfg_valid_next = acc.wdata[CWFM_CFG_VALID_BIT];
    if (wake_event || cfg_write || restart_pulse)
      cfg_valid_next = 1'b0;
  end

  // flag register
  always_ff @(posedge clk)
  begin
    if (srst || soft_reset)
      cfg_valid_reg <= 1'b0;
    else
      cfg_valid_reg <= cfg_valid_next;
  end

  assign config_valid_flag = cfg_valid_reg;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------

  cwfm_byte_t rd_byte;

  // stored bytes already hold zero in reserved bits; unmapped reads zero
  always_comb
  begin
    rd_byte = CWFM_BYTE_RESET;
    if (slot_hit(acc.idx))
      rd_byte = slot_reg[slot_of(acc.idx)] & wmask_of(slot_of(acc.idx));
    else if (acc.idx == CWFM_IDX_CONFIG_VALID)
      rd_byte[CWFM_CFG_VALID_BIT] = cfg_valid_reg;
  end

  assign acc.rdata = rd_byte;

  // ----------------------------------------------------------------
  // reference identifier and compare mask
  // ----------------------------------------------------------------

  cwfm_byte_t id_low;
  cwfm_byte_t mask_low;

  assign id_low = slot_reg[CWFM_SLOT_ID_LOW_FLAGS];
  assign mask_low = slot_reg[CWFM_SLOT_MASK_LOW];

  // identifier laid out as 28..21, 20..13, 12..5, 4..0
  assign ref_ident = {
    slot_reg[CWFM_SLOT_ID_TOP],
    slot_reg[CWFM_SLOT_ID_MID_HIGH],
    slot_reg[CWFM_SLOT_ID_MID_LOW],
    id_low[CWFM_LOW_ID_MSB:CWFM_LOW_ID_LSB]
  };

  // one bit means compared, zero means ignored by the comparator
  assign cmp_mask = {
    slot_reg[CWFM_SLOT_MASK_TOP],
    slot_reg[CWFM_SLOT_MASK_UPPER],
    slot_reg[CWFM_SLOT_MASK_MIDDLE],
    mask_low[CWFM_LOW_ID_MSB:CWFM_LOW_ID_LSB]
  };

  // standard identifiers live in the top eleven positions
  assign ref_std_ident = ref_ident[28:CWFM_STD_ID_LSB];

  // ----------------------------------------------------------------
  // frame format and type flags
  // ----------------------------------------------------------------

  assign ref_ide = id_low[CWFM_IDE_BIT];
  assign ref_rtr = id_low[CWFM_RTR_BIT];
  // remote frames cannot wake; flag a misprogrammed reference
  assign rtr_misconfig = id_low[CWFM_RTR_BIT];

  // ----------------------------------------------------------------
  // payload length and data bytes
  // ----------------------------------------------------------------

  cwfm_byte_t len_byte;

  assign len_byte = slot_reg[CWFM_SLOT_LENGTH_CODE];
  assign ref_length_code = len_byte[CWFM_DLC_MSB:0];

  cwfm_len_decode u_len (
    .length_code(len_byte[CWFM_DLC_MSB:0]),
    .byte_count(ref_byte_count)
  );

  assign ref_payload_byte_seven = slot_reg[CWFM_SLOT_BYTE_SEVEN];
  assign ref_payload_byte_six = slot_reg[CWFM_SLOT_BYTE_SIX];

endmodule

`default_nettype wire

// ===== src/cwfm_pkg.sv
// constants for the wake-frame match register bank
// assumes a 32-bit avalon-mm slave with one register per aligned word
package cwfm_pkg;

  // ----------------------------------------------------------------
  // address map: register indices, byte address is four times these
  // ----------------------------------------------------------------
  localparam int unsigned CWFM_ADDR_W = 8;
  localparam int unsigned CWFM_IDX_W = 6;
  localparam int unsigned CWFM_IDX_LSB = 2;
  localparam logic [5:0] CWFM_IDX_CONFIG_VALID = 6'h20;
  localparam logic [5:0] CWFM_IDX_WAKE_ID_TOP = 6'h23;
  localparam logic [5:0] CWFM_IDX_WAKE_ID_MID_HIGH = 6'h24;
  localparam logic [5:0] CWFM_IDX_WAKE_ID_MID_LOW = 6'h25;
  localparam logic [5:0] CWFM_IDX_WAKE_ID_LOW_FLAGS = 6'h26;
  localparam logic [5:0] CWFM_IDX_MASK_TOP = 6'h27;
  localparam logic [5:0] CWFM_IDX_MASK_UPPER = 6'h28;
  localparam logic [5:0] CWFM_IDX_MASK_MIDDLE = 6'h29;
  localparam logic [5:0] CWFM_IDX_MASK_LOW = 6'h2A;
  localparam logic [5:0] CWFM_IDX_LENGTH_CODE = 6'h2B;
  localparam logic [5:0] CWFM_IDX_BYTE_SEVEN = 6'h2C;
  localparam logic [5:0] CWFM_IDX_BYTE_SIX = 6'h2D;

  // ----------------------------------------------------------------
  // storage slots, counted from the top identifier byte
  // ----------------------------------------------------------------
  localparam int unsigned CWFM_NUM_SLOTS = 11;
  localparam logic [3:0] CWFM_SLOT_ID_TOP = 4'h0;
  localparam logic [3:0] CWFM_SLOT_ID_MID_HIGH = 4'h1;
  localparam logic [3:0] CWFM_SLOT_ID_MID_LOW = 4'h2;
  localparam logic [3:0] CWFM_SLOT_ID_LOW_FLAGS = 4'h3;
  localparam logic [3:0] CWFM_SLOT_MASK_TOP = 4'h4;
  localparam logic [3:0] CWFM_SLOT_MASK_UPPER = 4'h5;
  localparam logic [3:0] CWFM_SLOT_MASK_MIDDLE = 4'h6;
  localparam logic [3:0] CWFM_SLOT_MASK_LOW = 4'h7;
  localparam logic [3:0] CWFM_SLOT_LENGTH_CODE = 4'h8;
  localparam logic [3:0] CWFM_SLOT_BYTE_SEVEN = 4'h9;
  localparam logic [3:0] CWFM_SLOT_BYTE_SIX = 4'hA;

  // ----------------------------------------------------------------
  // field positions, writable-bit masks and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CWFM_IDE_BIT = 0;
  localparam int unsigned CWFM_RTR_BIT = 1;
  localparam int unsigned CWFM_CFG_VALID_BIT = 0;
  localparam int unsigned CWFM_LOW_ID_MSB = 6;
  localparam int unsigned CWFM_LOW_ID_LSB = 2;
  localparam int unsigned CWFM_DLC_MSB = 3;
  localparam int unsigned CWFM_STD_ID_LSB = 18;
  localparam logic [7:0] CWFM_WMASK_FULL = 8'hFF;
  localparam logic [7:0] CWFM_WMASK_ID_LOW_FLAGS = 8'h7F;
  localparam logic [7:0] CWFM_WMASK_MASK_LOW = 8'h7C;
  localparam logic [7:0] CWFM_WMASK_LENGTH_CODE = 8'h0F;
  localparam logic [7:0] CWFM_BYTE_RESET = 8'h00;
  localparam logic [3:0] CWFM_DLC_MAX_BYTES = 4'h8;

  typedef logic [7:0] cwfm_byte_t;

endpackage

// ===== src/cwfm_acc_if.sv
// one-byte register access strobes between bus slave and register bank
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none

interface cwfm_acc_if;
  logic wr_stb;
  logic rd_stb;
  logic [5:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport bus (output wr_stb, output rd_stb, output idx, output wdata, input rdata);
  modport bank (input wr_stb, input rd_stb, input idx, input wdata, output rdata);
endinterface

`default_nettype wire

// ===== src/cwfm_avmm_slave.sv
// avalon-mm slave front end with one wait state per access
// assumes the master holds its request until waitrequest is low
`timescale 1ns/100ps
`default_nettype none

module cwfm_avmm_slave
  import cwfm_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [cwfm_pkg::CWFM_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  cwfm_acc_if.bus acc
);
  import cwfm_pkg::*;

  logic ack_reg;
  logic [7:0] rdata_reg;

  // first cycle of a request waits, the second completes it
  assign waitrequest = (read | write) & ~ack_reg;
  assign acc.idx = address[CWFM_IDX_LSB +: CWFM_IDX_W];
  assign acc.wdata = writedata[7:0];
  // only lane 0 carries register data; a write without it changes nothing
  assign acc.wr_stb = write & ack_reg & byteenable[0];
  assign acc.rd_stb = read & ~ack_reg;
  assign readdata = {24'h000000, rdata_reg};

  // completion toggle
  always_ff @(posedge clk)
  begin
    if (srst)
      ack_reg <= 1'b0;
    else
      ack_reg <= (read | write) & ~ack_reg;
  end

  // read data captured in the wait cycle, stands at the completing edge
  always_ff @(posedge clk)
  begin
    if (srst)
      rdata_reg <= CWFM_BYTE_RESET;
    else if (acc.rd_stb)
      rdata_reg <= acc.rdata;
  end
endmodule

`default_nettype wire

// ===== src/cwfm_len_decode.sv
// turns a 4-bit data length code into a payload byte count
// assumes a classic can frame, never more than eight data bytes
`timescale 1ns/100ps
`default_nettype none

module cwfm_len_decode
  import cwfm_pkg::*;
(
  input wire logic [3:0] length_code,
  output logic [3:0] byte_count
);
  import cwfm_pkg::*;

  // codes 0..7 pass through, 8..15 all mean eight bytes
  always_comb
  begin
    if (length_code > CWFM_DLC_MAX_BYTES)
      byte_count = CWFM_DLC_MAX_BYTES;
    else
      byte_count = length_code;
  end
endmodule

`default_nettype wire

// ===== verif/cwfm_regs_top_assertions.sv
// port checker for the wake-frame register bank
// assumes one clock domain, bound onto cwfm_regs_top below
`timescale 1ns/100ps
`default_nettype none

module cwfm_regs_chk
  import cwfm_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic soft_reset,
  input wire logic restart_pulse,
  input wire logic wake_event,
  input wire logic [cwfm_pkg::CWFM_ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [28:0] ref_ident,
  input wire logic [28:0] cmp_mask,
  input wire logic [10:0] ref_std_ident,
  input wire logic ref_rtr,
  input wire logic rtr_misconfig,
  input wire logic [3:0] ref_length_code,
  input wire logic [3:0] ref_byte_count,
  input wire logic [7:0] ref_payload_byte_seven,
  input wire logic config_valid_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ----------------------------------------------------------------
  // bus timing, decoded fields, reset and flag behaviour
  // ----------------------------------------------------------------
  // at most one wait state, and never without a request
  wait_state_a: assert property (waitrequest |=> !waitrequest)
    else $error("waitrequest held longer than one cycle");
  wait_cause_a: assert property (waitrequest |-> (read || write))
    else $error("waitrequest without a request");
  std_ident_a: assert property (ref_std_ident == ref_ident[28:18])
    else $error("standard id not taken from bits 28 to 18");
  byte_count_a: assert property (ref_byte_count ==
    ((ref_length_code > 4'h8) ? 4'h8 : ref_length_code))
    else $error("byte count does not follow the length code");
  // the remote request flag only comes up through a write to the low id register
  rtr_flag_a: assert property ((rtr_misconfig == ref_rtr) && (!$rose(rtr_misconfig) ||
    $past(write && !waitrequest && byteenable[0] && address[7:2] == 6'h26)))
    else $error("remote request flag raised without a write");
  reserved_read_a: assert property (readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  soft_clear_a: assert property (soft_reset |=> ref_ident == 29'h0 &&
    cmp_mask == 29'h0 && ref_length_code == 4'h0 && !config_valid_flag &&
    ref_payload_byte_seven == 8'h00)
    else $error("soft reset left a register set");
  // restart keeps the frame but drops the valid flag
  restart_keep_a: assert property (restart_pulse && !soft_reset && !write |=>
    $stable(ref_ident) && $stable(cmp_mask) && !config_valid_flag)
    else $error("restart changed the frame or kept the flag");
  wake_clear_a: assert property (wake_event |=> !config_valid_flag)
    else $error("wake did not clear the valid flag");
  cfg_write_a: assert property (write && !waitrequest && byteenable[0] &&
    address[7:2] >= 6'h23 && address[7:2] <= 6'h2D |=> !config_valid_flag)
    else $error("config change did not clear the valid flag");
  // the identifier only moves after a completed write or a reset
  ident_hold_a: assert property (!$stable(ref_ident) |->
    $past(write && !waitrequest) || $past(soft_reset) || $past(srst))
    else $error("identifier changed without a write");
endmodule

bind cwfm_regs_top cwfm_regs_chk u_chk (.clk(clk), .srst(srst), .soft_reset(soft_reset),
  .restart_pulse(restart_pulse), .wake_event(wake_event), .address(address), .read(read),
  .write(write), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .ref_ident(ref_ident), .cmp_mask(cmp_mask), .ref_std_ident(ref_std_ident),
  .ref_rtr(ref_rtr), .rtr_misconfig(rtr_misconfig), .ref_length_code(ref_length_code),
  .ref_byte_count(ref_byte_count), .ref_payload_byte_seven(ref_payload_byte_seven),
  .config_valid_flag(config_valid_flag));

`default_nettype wire

// ===== verif/cwfm_frame_model.sv
// frame comparator model fed by the reference outputs
// assumes one received frame held as plain levels
`timescale 1ns/100ps
`default_nettype none

module cwfm_frame_model
(
  input wire logic [28:0] ref_ident,
  input wire logic [28:0] cmp_mask,
  input wire logic ref_ide,
  input wire logic ref_rtr,
  input wire logic [28:0] rx_ident,
  input wire logic rx_ide,
  input wire logic rx_rtr,
  output logic hit
);
  logic [28:0] used;

  // standard frames carry only the top eleven bits
  always_comb
  begin
    used = ref_ide ? cmp_mask : {cmp_mask[28:18], 18'h0};
    hit = (((rx_ident ^ ref_ident) & used) == 29'h0) &&
      (rx_ide == ref_ide) && (rx_rtr == ref_rtr);
  end
endmodule

`default_nettype wire

// ===== verif/cwfm_regs_top_bench.sv
// self-checking bench for the wake-frame register bank
// assumes the checker is bound in and the frame model sits on the outputs
`timescale 1ns/100ps
`default_nettype none

module cwfm_regs_top_bench;
  import cwfm_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic soft_reset = 1'b0;
  logic restart_pulse = 1'b0;
  logic wake_event = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic [28:0] rx_ident = 29'h0;
  logic rx_ide = 1'b1;
  logic [31:0] readdata;
  logic waitrequest, ref_ide, ref_rtr, rtr_misconfig, config_valid_flag, hit;
  logic [28:0] ref_ident, cmp_mask;
  logic [10:0] ref_std_ident;
  logic [3:0] ref_length_code, ref_byte_count;
  logic [7:0] ref_payload_byte_seven, ref_payload_byte_six, q;
  int n_errors = 0;
  int n_tests = 0;

  always #20 clk = ~clk;

  cwfm_regs_top dut (.clk(clk), .srst(srst), .soft_reset(soft_reset),
    .restart_pulse(restart_pulse), .wake_event(wake_event), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .ref_ident(ref_ident), .cmp_mask(cmp_mask),
    .ref_std_ident(ref_std_ident), .ref_ide(ref_ide), .ref_rtr(ref_rtr),
    .rtr_misconfig(rtr_misconfig), .ref_length_code(ref_length_code),
    .ref_byte_count(ref_byte_count), .ref_payload_byte_seven(ref_payload_byte_seven),
    .ref_payload_byte_six(ref_payload_byte_six), .config_valid_flag(config_valid_flag));
  cwfm_frame_model far (.ref_ident(ref_ident), .cmp_mask(cmp_mask), .ref_ide(ref_ide),
    .ref_rtr(ref_rtr), .rx_ident(rx_ident), .rx_ide(rx_ide), .rx_rtr(1'b0), .hit(hit));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until waitrequest is sampled low; an idle edge follows
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d,
    input logic [3:0] be);
    int k;
    k = 0;
    address <= {idx, 2'b00};
    writedata <= {24'h0, d};
    byteenable <= be;
    write <= wr;
    read <= !wr;
    @(posedge clk);
    while (waitrequest !== 1'b0)
    begin
      k++;
      if (k > 16)
      begin
        n_errors++;
        end_of_test();
      end
      @(posedge clk);
    end
    q = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 4'h1);
    check({24'h0, q}, {24'h0, exp});
  endtask

  // sel 0 soft reset, 1 restart, 2 wake, each for a single edge
  task automatic pulse(input logic [1:0] sel);
    {soft_reset, restart_pulse, wake_event} <= 3'b100 >> sel;
    @(posedge clk);
    {soft_reset, restart_pulse, wake_event} <= 3'b000;
    @(posedge clk);
  endtask

  // read-back after all-ones writes; the flag was cleared by later bank writes
  function automatic logic [7:0] wmask(input logic [5:0] idx);
    case (idx)
      6'h20, 6'h21, 6'h22: return 8'h00;
      6'h26: return 8'h7F;
      6'h2A: return 8'h7C;
      6'h2B: return 8'h0F;
      default: return 8'hFF;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_zero;
    for (int i = 32; i < 46; i++)
      rd(i[5:0], 8'h00);
  endtask

  task automatic t_access;
    for (int i = 32; i < 46; i++)
      wr(i[5:0], 8'hFF);
    for (int i = 32; i < 46; i++)
      rd(i[5:0], wmask(i[5:0]));
    check({3'h0, cmp_mask}, 32'h1FFFFFFF);
    check({3'h0, ref_ident}, 32'h1FFFFFFF);
    pulse(2'd0);
    t_zero();
  endtask

  task automatic t_match;
    wr(CWFM_IDX_WAKE_ID_TOP, 8'hAA);
    wr(CWFM_IDX_WAKE_ID_MID_HIGH, 8'h55);
    wr(CWFM_IDX_WAKE_ID_MID_LOW, 8'hF0);
    wr(CWFM_IDX_WAKE_ID_LOW_FLAGS, 8'h4D);
    for (int i = 39; i < 43; i++)
      wr(i[5:0], 8'hFF);
    check({3'h0, ref_ident}, 32'h154ABE13);
    check(32'(ref_std_ident), 32'h552);
    rx_ident <= 29'h154ABE13;
    @(posedge clk);
    check(32'(hit), 32'h1);
    rx_ident <= 29'h154ABE12;
    @(posedge clk);
    check(32'(hit), 32'h0);
    wr(CWFM_IDX_MASK_LOW, 8'h78);
    check(32'(hit), 32'h1);
    wr(CWFM_IDX_WAKE_ID_LOW_FLAGS, 8'h4C);
    check(32'(ref_ide), 32'h0);
    // standard frame: a low-bit difference is ignored, a top-bit one is not
    rx_ide <= 1'b0;
    rx_ident <= 29'h154ABE03;
    @(posedge clk);
    check(32'(hit), 32'h1);
    rx_ident <= 29'h150ABE03;
    @(posedge clk);
    check(32'(hit), 32'h0);
    wr(CWFM_IDX_WAKE_ID_LOW_FLAGS, 8'h02);
    check({30'h0, ref_rtr, rtr_misconfig}, 32'h3);
  endtask

  task automatic t_length;
    for (int c = 0; c < 16; c++)
    begin
      wr(CWFM_IDX_LENGTH_CODE, {4'hF, c[3:0]});
      check(32'(ref_byte_count), (c > 8) ? 32'h8 : 32'(c));
      check(32'(ref_length_code), 32'(c));
      rd(CWFM_IDX_LENGTH_CODE, {4'h0, c[3:0]});
    end
  endtask

  task automatic t_valid;
    wr(CWFM_IDX_CONFIG_VALID, 8'h01);
    check(32'(config_valid_flag), 32'h1);
    wr(CWFM_IDX_BYTE_SEVEN, 8'h5A);
    check(32'(config_valid_flag), 32'h0);
    wr(CWFM_IDX_CONFIG_VALID, 8'h01);
    pulse(2'd2);
    check(32'(config_valid_flag), 32'h0);
    wr(CWFM_IDX_CONFIG_VALID, 8'h01);
    pulse(2'd1);
    check(32'(config_valid_flag), 32'h0);
    rd(CWFM_IDX_BYTE_SEVEN, 8'h5A);
    check(32'(ref_payload_byte_seven), 32'h5A);
    bus(1'b1, CWFM_IDX_BYTE_SIX, 8'h3C, 4'h0);
    rd(CWFM_IDX_BYTE_SIX, 8'h00);
    wr(CWFM_IDX_BYTE_SIX, 8'h3C);
    check(32'(ref_payload_byte_six), 32'h3C);
    wr(6'h3F, 8'hFF);
    rd(6'h3F, 8'h00);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(CWFM_IDX_BYTE_SEVEN, 8'h00);
    check(32'(ref_payload_byte_six), 32'h0);
  endtask

  // reset for two edges, then every scenario in turn
  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_zero();
    t_access();
    t_match();
    t_length();
    t_valid();
    end_of_test();
  end
endmodule

`default_nettype wire
